//--- core/hs_pkg.sv
// Constants for the instrument bus adapter: register map, field bits,
// reset values, bus command codes and handshake states.
// Assumes a single 100 MHz processor clock driving every register.
package hs_pkg;
   // Register indexes, selected by the three select lines
   localparam logic [2:0] REG_INT   = 3'h0;
   localparam logic [2:0] REG_CMD   = 3'h1;
   localparam logic [2:0] REG_ADDR  = 3'h2;
   localparam logic [2:0] REG_AUX   = 3'h3;
   localparam logic [2:0] REG_SW    = 3'h4;
   localparam logic [2:0] REG_SPOLL = 3'h5;
   localparam logic [2:0] REG_PASS  = 3'h6;
   localparam logic [2:0] REG_DATA  = 3'h7;
   // Interrupt status and mask bits
   localparam int ST_BO  = 6;
   localparam int ST_GET = 5;
   localparam int ST_APT = 3;
   localparam int ST_CMD = 2;
   localparam int ST_END = 1;
   localparam int ST_BI  = 0;
   // Command status bits
   localparam int CS_UNDEFINED_ADDRESSED_COMMAND = 7;
   localparam int CS_RLC  = 3;
   localparam int CS_SERIAL_POLL_ACTIVE = 2;
   localparam int CS_DEVICE_CLEAR_ACTIVE = 1;
   localparam int CS_UNDEFINED_UNIVERSAL_COMMAND = 0;
   // Addressing mode bits
   localparam int MD_DSEL = 7;
   localparam int MD_TO   = 6;
   localparam int MD_LO   = 5;
   localparam int MD_HLDA = 2;
   localparam int MD_APTE = 0;
   // Auxiliary command bits
   localparam int AX_SWRST = 7;
   localparam int AX_RFDR  = 6;
   localparam int AX_FGET  = 0;
   localparam logic [7:0] AUX_RST = 8'h80;
   // Bus command codes, seven bits
   localparam logic [6:0] CMD_GET = 7'h08;
   localparam logic [6:0] CMD_SDC = 7'h04;
   localparam logic [6:0] CMD_DCL = 7'h14;
   localparam logic [6:0] CMD_SPE = 7'h18;
   localparam int FIFO_DEPTH = 32;
   localparam int DATA_W     = 8;
   typedef enum logic [2:0] {
      HS_IDLE    = 3'b000,
      HS_L_RDY   = 3'b001,
      HS_L_ACC   = 3'b011,
      HS_L_DONE  = 3'b010,
      HS_T_VALID = 3'b110
   } hs_state_t;
endpackage

//--- core/instrument_bus_dma_handshake.sv
// Processor-side register file, DMA handshake, trigger and bus
// handshakes of an instrument bus adapter, plus its transmit FIFO.
// Assumes the processor bus runs on sys_clk; bus pins are asynchronous.

module tx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("tx_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
   logic             push, pop;

   always_comb begin
      in_ready  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
      out_valid = (wp_q != rp_q);
      out_data  = mem_q[rp_q[AW-1:0]];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wp_d      = wp_q + {{AW{1'b0}}, push};
      rp_d      = rp_q + {{AW{1'b0}}, pop};
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wp_q[AW-1:0]] <= in_data;
      end
   end
endmodule // tx_fifo

// Operation
// - Request DMA while byte in or out set
// - Drop DMA request when grant arrives
// - Grant selects data register, ignores select lines
// - Grant inverts read/write meaning
// - Any reset forces trigger low
// - Force-trigger bit holds trigger high
// - GET raises trigger until leaving trigger state
// - Switch read pulses buffer enable low
// - Handshake lines synchronised and debounced
// - Listener starts with RFD, debounced handshake
// - Talker drives DAV on RFD and new byte
// - Talker handshake passes through debounce
// - Fifteen locations from select lines and read/write
// - DAC held low until data read
// - Holdoff blocks new data handshake until released, command bytes still pass
// - Data in and out stores independent
// - Command interrupt sources depend on select bit
// - GET sets its status bit
// - EOI with ATN high sets end bit
// - Primary then secondary offered when passing through
// - Byte-in flag set when data in full
// - Byte-out flag set when byte accepted
// - Reset clears poll and data registers
module instrument_bus_dma_handshake (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       cs_n,
   input  wire logic       rw,
   input  wire logic [2:0] register_select,
   input  wire logic [7:0] cpu_wdata,
   output logic      [7:0] cpu_rdata,
   output logic            cpu_rdata_oe,
   input  wire logic       dma_grant,
   output logic            dma_request,
   output logic            sync_pulse_output,
   output logic            switch_buffer_enable_n,
   input  wire logic [7:0] switch_in,
   output logic            tx_ready,
   input  wire logic       atn_in,
   input  wire logic       eoi_in,
   input  wire logic       ren_in,
   input  wire logic [7:0] dio_in,
   output logic      [7:0] dio_out,
   output logic            dio_oe,
   input  wire logic       dav_in,
   output logic            dav_out,
   output logic            dav_oe,
   input  wire logic       rfd_in,
   output logic            rfd_out,
   output logic            rfd_oe,
   input  wire logic       dac_in,
   output logic            dac_out,
   output logic            dac_oe
);
   localparam int PW = 22;
   logic [PW-1:0] pin_raw, s1_q, s2_q;
   logic [7:0]    sw_s, dio_s;
   logic          ren_s, eoi_s, atn_s;
   logic [2:0]    hs_s, hs_prev_q, hs_deb_q, hs_deb_d, stable;
   logic          dav_d, rfd_d, dac_d;

   // Pin synchronisers
   assign pin_raw = {switch_in, dio_in, ren_in, eoi_in, atn_in, dav_in, rfd_in, dac_in};
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         // Idle levels: control and handshake lines high, data and switch lines low, no false edge
         s1_q <= {16'h0000, 6'h3f};
         s2_q <= {16'h0000, 6'h3f};
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
      end
   end
   assign sw_s  = s2_q[21:14];
   assign dio_s = s2_q[13:6];
   assign ren_s = s2_q[5];
   assign eoi_s = s2_q[4];
   assign atn_s = s2_q[3];
   assign hs_s  = s2_q[2:0];

   // Handshake line only moves after two equal samples
   always_comb begin
      stable   = ~(hs_s ^ hs_prev_q);
      hs_deb_d = (stable & hs_s) | (~stable & hs_deb_q);
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hs_prev_q <= 3'h7;
         hs_deb_q  <= 3'h7;
      end else begin
         hs_prev_q <= hs_s;
         hs_deb_q  <= hs_deb_d;
      end
   end
   assign dav_d = hs_deb_q[2];
   assign rfd_d = hs_deb_q[1];
   assign dac_d = hs_deb_q[0];

   // Processor bus decode
   logic       access, rd_acc, wr_acc, wr_ok, swrst;
   logic [2:0] ridx;
   always_comb begin
      access = dma_grant | ~cs_n;
      ridx   = dma_grant ? hs_pkg::REG_DATA : register_select;
      rd_acc = access & (rw ^ dma_grant);
      wr_acc = access & ~(rw ^ dma_grant);
      wr_ok  = wr_acc & (~swrst | ridx == hs_pkg::REG_AUX | ridx == hs_pkg::REG_SW);
   end

   // Transmit FIFO in front of the data-out store
   logic       fifo_rdy, fifo_v, fifo_pop, push;
   logic [7:0] fifo_data;
   logic       nba_q, nba_d;
   assign push     = wr_ok & ridx == hs_pkg::REG_DATA;
   assign fifo_pop = fifo_v & ~nba_q;
   tx_fifo #(
      .WIDTH(hs_pkg::DATA_W),
      .DEPTH(hs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .in_valid (push),
      .in_ready (fifo_rdy),
      .in_data  (cpu_wdata),
      .out_valid(fifo_v),
      .out_ready(~nba_q),
      .out_data (fifo_data)
   );

   hs_pkg::hs_state_t st_q, st_d;
   logic [7:0] mask_q, mask_d, mode_q, mode_d, aux_q, aux_d, addr_q, addr_d;
   logic [7:0] spoll_q, spoll_d, ppoll_q, ppoll_d, din_q, din_d, dout_q, dout_d;
   logic [7:0] cpt_q, cpt_d, stat_q, stat_d, cstat_q, cstat_d, rdata_q, rdata_d;
   logic       holdoff_q, holdoff_d, dtas_q, dtas_d, is_cmd_q, is_cmd_d;
   logic       prim_q, prim_d, ren_prev_q, dreq_q, dreq_d, sync_pulse_output_q, sync_pulse_output_d;
   logic       ase_n_q, ase_n_d, rdoe_q, dio_oe_q, dav_oe_q, rfd_oe_q, dac_oe_q;
   logic       rfd_oe_d, dac_oe_d, dav_oe_d, txr_q, lact, tact, cmd_evt;
   logic [6:0] cb;
   logic [7:0] rval;

   assign swrst = aux_q[hs_pkg::AX_SWRST];

   always_comb begin
      mask_d    = mask_q;
      mode_d    = mode_q;
      aux_d     = aux_q;
      addr_d    = addr_q;
      spoll_d   = spoll_q;
      ppoll_d   = ppoll_q;
      din_d     = din_q;
      dout_d    = dout_q;
      cpt_d     = cpt_q;
      stat_d    = stat_q;
      cstat_d   = cstat_q;
      holdoff_d = holdoff_q;
      dtas_d    = dtas_q;
      is_cmd_d  = is_cmd_q;
      prim_d    = prim_q;
      nba_d     = nba_q;
      st_d      = st_q;
      cmd_evt   = 1'b0;
      cb        = dio_s[6:0];
      lact      = ~swrst & (~atn_s | mode_q[hs_pkg::MD_LO]);
      tact      = ~swrst & atn_s & mode_q[hs_pkg::MD_TO];
      // Writes, seven write locations
      if (wr_ok) begin
         case (ridx)
            hs_pkg::REG_INT:   mask_d  = cpu_wdata;
            hs_pkg::REG_ADDR:  mode_d  = cpu_wdata;
            hs_pkg::REG_AUX:   aux_d   = cpu_wdata;
            hs_pkg::REG_SW:    addr_d  = cpu_wdata;
            hs_pkg::REG_SPOLL: spoll_d = cpu_wdata;
            hs_pkg::REG_PASS:  ppoll_d = cpu_wdata;
            default: ;
         endcase
      end
      if (wr_ok && ridx == hs_pkg::REG_AUX && cpu_wdata[hs_pkg::AX_RFDR]) begin
         holdoff_d = 1'b0;
      end
      // Clears by reads and writes, ahead of hardware sets
      if (rd_acc && ridx == hs_pkg::REG_INT) begin
         stat_d[hs_pkg::ST_GET] = 1'b0;
         stat_d[hs_pkg::ST_APT] = 1'b0;
         stat_d[hs_pkg::ST_CMD] = 1'b0;
         stat_d[hs_pkg::ST_END] = 1'b0;
      end
      if (rd_acc && ridx == hs_pkg::REG_CMD) begin
         cstat_d = 8'h00;
      end
      if (rd_acc && ridx == hs_pkg::REG_DATA) begin
         stat_d[hs_pkg::ST_BI] = 1'b0;
      end
      if (push && fifo_rdy) begin
         stat_d[hs_pkg::ST_BO] = 1'b0;
      end
      if (fifo_pop) begin
         dout_d = fifo_data;
         nba_d  = 1'b1;
      end
      if (ren_s != ren_prev_q) begin
         cstat_d[hs_pkg::CS_RLC] = 1'b1;
         cmd_evt = 1'b1;
      end
      case (st_q)
         hs_pkg::HS_IDLE: begin
            if (tact && nba_q && rfd_d) begin
               st_d = hs_pkg::HS_T_VALID;
            end else if (lact && (~atn_s || (~stat_q[hs_pkg::ST_BI] && ~holdoff_q))) begin
               st_d = hs_pkg::HS_L_RDY;
            end
         end
         hs_pkg::HS_L_RDY: begin
            if (!lact) begin
               st_d = hs_pkg::HS_IDLE;
            end else if (!dav_d) begin
               st_d     = hs_pkg::HS_L_ACC;
               is_cmd_d = ~atn_s;
               if (atn_s) begin
                  din_d                 = dio_s;
                  stat_d[hs_pkg::ST_BI] = 1'b1;
                  if (!eoi_s) begin
                     stat_d[hs_pkg::ST_END] = 1'b1;
                  end
                  if (mode_q[hs_pkg::MD_HLDA]) begin
                     holdoff_d = 1'b1;
                  end
               end else begin
                  dtas_d = (cb == hs_pkg::CMD_GET) & ~dtas_q;
                  prim_d = (cb[6:5] == 2'b01 || cb[6:5] == 2'b10)
                           && cb[4:0] == addr_q[4:0];
                  if (cb == hs_pkg::CMD_GET) begin
                     stat_d[hs_pkg::ST_GET] = 1'b1;
                  end else if (cb == hs_pkg::CMD_SPE) begin
                     cstat_d[hs_pkg::CS_SERIAL_POLL_ACTIVE] = 1'b1;
                     cmd_evt = 1'b1;
                  end else if (cb == hs_pkg::CMD_DCL || cb == hs_pkg::CMD_SDC) begin
                     cstat_d[hs_pkg::CS_DEVICE_CLEAR_ACTIVE] = 1'b1;
                     cmd_evt = cmd_evt | ~mode_q[hs_pkg::MD_DSEL];
                  end else if (cb[6:5] == 2'b00) begin
                     if (cb[4]) begin
                        cstat_d[hs_pkg::CS_UNDEFINED_UNIVERSAL_COMMAND] = 1'b1;
                     end else begin
                        cstat_d[hs_pkg::CS_UNDEFINED_ADDRESSED_COMMAND] = 1'b1;
                     end
                     cmd_evt = cmd_evt | ~mode_q[hs_pkg::MD_DSEL];
                  end else if (cb[6:5] == 2'b11 && prim_q && mode_q[hs_pkg::MD_APTE]) begin
                     cpt_d                  = {1'b0, cb};
                     stat_d[hs_pkg::ST_APT] = 1'b1;
                  end
               end
            end
         end
         hs_pkg::HS_L_ACC: begin
            if (is_cmd_q || (rd_acc && ridx == hs_pkg::REG_DATA)) begin
               st_d = hs_pkg::HS_L_DONE;
            end
         end
         hs_pkg::HS_L_DONE: begin
            if (dav_d) begin
               st_d = hs_pkg::HS_IDLE;
            end
         end
         hs_pkg::HS_T_VALID: begin
            if (!tact) begin
               st_d = hs_pkg::HS_IDLE;
            end else if (dac_d) begin
               st_d                  = hs_pkg::HS_IDLE;
               nba_d                 = 1'b0;
               stat_d[hs_pkg::ST_BO] = 1'b1;
            end
         end
         default: st_d = hs_pkg::HS_IDLE;
      endcase
      if (cmd_evt) begin
         stat_d[hs_pkg::ST_CMD] = 1'b1;
      end
      if (swrst) begin
         dtas_d = 1'b0;
      end
      // Outputs
      dreq_d   = (stat_q[hs_pkg::ST_BI] | stat_q[hs_pkg::ST_BO]) & ~dma_grant;
      sync_pulse_output_d   = ~swrst & (aux_q[hs_pkg::AX_FGET] | dtas_q);
      ase_n_d  = ~(rd_acc && ridx == hs_pkg::REG_SW);
      rfd_oe_d = lact & (st_q != hs_pkg::HS_L_RDY);
      dac_oe_d = lact & (st_q != hs_pkg::HS_L_DONE);
      dav_oe_d = (st_q == hs_pkg::HS_T_VALID);
      // Eight read locations
      case (ridx)
         hs_pkg::REG_INT:   rval = {|(stat_q[6:0] & mask_q[6:0]), stat_q[6:0]};
         hs_pkg::REG_CMD:   rval = cstat_q;
         hs_pkg::REG_ADDR:  rval = {1'b0, mode_q[6:5], atn_s, tact, lact, 2'b00};
         hs_pkg::REG_AUX:   rval = {swrst, ~dac_oe_q, dav_d, rfd_d, aux_q[3:0]};
         hs_pkg::REG_SW:    rval = sw_s;
         hs_pkg::REG_SPOLL: rval = spoll_q;
         hs_pkg::REG_PASS:  rval = cpt_q;
         default:           rval = din_q;
      endcase
      rdata_d = rd_acc ? rval : 8'h00;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mask_q     <= 8'h00;
         mode_q     <= 8'h00;
         aux_q      <= hs_pkg::AUX_RST;
         addr_q     <= 8'h00;
         spoll_q    <= 8'h00;
         ppoll_q    <= 8'h00;
         din_q      <= 8'h00;
         dout_q     <= 8'h00;
         cpt_q      <= 8'h00;
         stat_q     <= 8'h00;
         cstat_q    <= 8'h00;
         holdoff_q  <= 1'b0;
         dtas_q     <= 1'b0;
         is_cmd_q   <= 1'b0;
         prim_q     <= 1'b0;
         nba_q      <= 1'b0;
         ren_prev_q <= 1'b1;
         st_q       <= hs_pkg::HS_IDLE;
         dreq_q     <= 1'b0;
         sync_pulse_output_q     <= 1'b0;
         ase_n_q    <= 1'b1;
         rdata_q    <= 8'h00;
         rdoe_q     <= 1'b0;
         dio_oe_q   <= 1'b0;
         dav_oe_q   <= 1'b0;
         rfd_oe_q   <= 1'b0;
         dac_oe_q   <= 1'b0;
         txr_q      <= 1'b0;
      end else begin
         mask_q     <= mask_d;
         mode_q     <= mode_d;
         aux_q      <= aux_d;
         addr_q     <= addr_d;
         spoll_q    <= spoll_d;
         ppoll_q    <= ppoll_d;
         din_q      <= din_d;
         dout_q     <= dout_d;
         cpt_q      <= cpt_d;
         stat_q     <= stat_d;
         cstat_q    <= cstat_d;
         holdoff_q  <= holdoff_d;
         dtas_q     <= dtas_d;
         is_cmd_q   <= is_cmd_d;
         prim_q     <= prim_d;
         nba_q      <= nba_d;
         ren_prev_q <= ren_s;
         st_q       <= st_d;
         dreq_q     <= dreq_d;
         sync_pulse_output_q     <= sync_pulse_output_d;
         ase_n_q    <= ase_n_d;
         rdata_q    <= rdata_d;
         rdoe_q     <= rd_acc;
         dio_oe_q   <= tact;
         dav_oe_q   <= dav_oe_d;
         rfd_oe_q   <= rfd_oe_d;
         dac_oe_q   <= dac_oe_d;
         txr_q      <= fifo_rdy;
      end
   end

   assign cpu_rdata              = rdata_q;
   assign cpu_rdata_oe           = rdoe_q;
   assign dma_request            = dreq_q;
   assign sync_pulse_output      = sync_pulse_output_q;
   assign switch_buffer_enable_n = ase_n_q;
   assign tx_ready               = txr_q;
   assign dio_out                = dout_q;
   assign dio_oe                 = dio_oe_q;
   assign dav_out                = ppoll_q[0] & 1'b0;
   assign dav_oe                 = dav_oe_q;
   assign rfd_out                = dav_out;
   assign rfd_oe                 = rfd_oe_q;
   assign dac_out                = dav_out;
   assign dac_oe                 = dac_oe_q;

   default clocking cb_clk @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence byte_taken;
      st_q == hs_pkg::HS_L_RDY ##1 st_q == hs_pkg::HS_L_ACC && !is_cmd_q;
   endsequence

   dreq_flags_a: assert property ((stat_q[0] | stat_q[6]) && !dma_grant |=> dma_request)
      else $error("dma request missing");
   dreq_grant_a: assert property (dma_grant |=> !dma_request)
      else $error("dma request during grant");
   grant_read_a: assert property (dma_grant && !rw |=> cpu_rdata_oe && cpu_rdata == $past(din_q))
      else $error("grant read not data in");
   sync_pulse_output_reset_a: assert property (swrst |=> !sync_pulse_output)
      else $error("trigger high in reset");
   fget_sync_pulse_output_a: assert property (aux_q[0] && !swrst |=> sync_pulse_output)
      else $error("forced trigger missing");
   ase_pulse_a: assert property (rd_acc && ridx == 3'h4 |=> !switch_buffer_enable_n ##1
      (switch_buffer_enable_n || $past(rd_acc)))
      else $error("switch enable pulse wrong");
   dav_cause_a: assert property ($rose(dav_oe) |-> $past(rfd_d, 2) && $past(nba_q, 2))
      else $error("data valid without cause");
   dac_hold_a: assert property (byte_taken ##0 !(rd_acc && ridx == 3'h7)
      |=> st_q == hs_pkg::HS_L_ACC && dac_oe)
      else $error("data accepted before read");
   holdoff_a: assert property (holdoff_q && atn_s && st_q == hs_pkg::HS_IDLE
      |=> st_q != hs_pkg::HS_L_RDY)
      else $error("holdoff ignored");
   dout_keep_a: assert property (rd_acc && ridx == 3'h7 && !fifo_pop |=> dout_q == $past(dout_q))
      else $error("data out changed by read");
endmodule // instrument_bus_dma_handshake

//--- verif/dma_ctrl_model.sv
// DMA controller model: answers a pending request with one grant cycle.
// Assumes the device samples grant and read/write on the rising edge.
module dma_ctrl_model (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       dma_request,
   input  wire logic [7:0] cpu_rdata,
   output logic            dma_grant,
   output logic            dma_rw,
   output logic      [7:0] got_byte,
   output logic            got
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(negedge sys_clk or posedge rst) begin
      if (rst) begin
         dma_grant <= 1'b0;
         dma_rw    <= 1'b1;
         got_byte  <= 8'h00;
         got       <= 1'b0;
      end else if (dma_grant) begin
         // Read data stands in the cycle after the grant cycle
         dma_grant <= 1'b0;
         dma_rw    <= 1'b1;
         got_byte  <= cpu_rdata;
         got       <= 1'b1;
      end else if (enable && dma_request && !got) begin
         dma_grant <= 1'b1;
         dma_rw    <= 1'b0; // Memory write cycle fetches data
      end
   end
endmodule // dma_ctrl_model

//--- verif/instrument_bus_dma_handshake_tb_top.sv
// Self-checking bench for the adapter: registers, trigger, switches,
// listener, talker and DMA paths. Plays the bus talker and listener.
module instrument_bus_dma_handshake_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       sys_clk, rst, cs_n, cpu_rw, rw, dio_oe, dav_oe, rfd_oe, dac_oe;
   logic       atn_t, dav_t, rfd_l, dac_l, dma_en, dma_grant, dma_rw, got;
   logic       dma_request, sync_pulse_output, switch_buffer_enable_n, tx_ready;
   logic       dav_out, rfd_out, dac_out, cpu_rdata_oe;
   logic [2:0] register_select;
   logic [7:0] cpu_wdata, cpu_rdata, switch_in, dio_t, dio_out, got_byte, d;
   int         fails, num_checks, cycles;
   // Wired handshake lines with pull-ups
   wire logic       dav_in = dav_t & ~dav_oe;
   wire logic       rfd_in = rfd_l & ~rfd_oe;
   wire logic       dac_in = dac_l & ~dac_oe;
   wire logic [7:0] dio_in = dio_oe ? dio_out : dio_t;
   assign rw = dma_grant ? dma_rw : cpu_rw;

   instrument_bus_dma_handshake dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .rw(rw),
      .register_select(register_select), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_rdata_oe(cpu_rdata_oe), .dma_grant(dma_grant), .dma_request(dma_request),
      .sync_pulse_output(sync_pulse_output), .switch_buffer_enable_n(switch_buffer_enable_n),
      .switch_in(switch_in), .tx_ready(tx_ready), .atn_in(atn_t), .eoi_in(1'b1),
      .ren_in(1'b1), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe), .dav_in(dav_in),
      .dav_out(dav_out), .dav_oe(dav_oe), .rfd_in(rfd_in), .rfd_out(rfd_out),
      .rfd_oe(rfd_oe), .dac_in(dac_in), .dac_out(dac_out), .dac_oe(dac_oe));
   dma_ctrl_model dma (.sys_clk(sys_clk), .rst(rst), .enable(dma_en),
      .dma_request(dma_request), .cpu_rdata(cpu_rdata), .dma_grant(dma_grant),
      .dma_rw(dma_rw), .got_byte(got_byte), .got(got));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      if (fails == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return rfd_oe;
         1: return dac_oe;
         2: return dav_oe;
         default: return dma_request;
      endcase
   endfunction

   task automatic wait_for(input int s, input logic v);
      int n;
      n = 0;
      while (pick(s) !== v && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      chk("wait", 8'(n < 200), 8'h01);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      cs_n = 1'b0;
      cpu_rw = 1'b0;
      register_select = a;
      cpu_wdata = v;
      @(negedge sys_clk);
      cs_n = 1'b1;
      @(negedge sys_clk);
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      cs_n = 1'b0;
      cpu_rw = 1'b1;
      register_select = a;
      @(negedge sys_clk);
      cs_n = 1'b1;
      v = cpu_rdata;
      chk("rdata_oe", 8'(cpu_rdata_oe), 8'h01);
      chk("ase_pulse", 8'(switch_buffer_enable_n), 8'(a != hs_pkg::REG_SW));
      @(negedge sys_clk);
      chk("ase_idle", 8'(switch_buffer_enable_n), 8'h01);
   endtask

   task automatic bus_byte(input logic [7:0] b);
      wait_for(0, 1'b1);
      wait_for(0, 1'b0);
      dio_t = b;
      dav_t = 1'b0;
      wait_for(0, 1'b1);
   endtask

   task automatic t_trigger();
      wr(hs_pkg::REG_AUX, 8'h01);
      chk("sync_pulse_output_set", 8'(sync_pulse_output), 8'h01);
      wr(hs_pkg::REG_AUX, 8'h00);
      chk("sync_pulse_output_clr", 8'(sync_pulse_output), 8'h00);
      wr(hs_pkg::REG_AUX, 8'h01);
      wr(hs_pkg::REG_AUX, hs_pkg::AUX_RST);
      chk("sync_pulse_output_swrst", 8'(sync_pulse_output), 8'h00);
      wr(hs_pkg::REG_AUX, 8'h00);
      rd(hs_pkg::REG_SW, d);
      chk("switches", d, 8'ha5);
   endtask

   task automatic t_listen_dma();
      wr(hs_pkg::REG_ADDR, 8'h20);
      bus_byte(8'h5a);
      wait_for(3, 1'b1);
      chk("dac_hold", 8'(dac_oe), 8'h01);
      register_select = hs_pkg::REG_SW;
      dma_en = 1'b1;
      wait (got === 1'b1);
      @(negedge sys_clk);
      chk("dma_byte", got_byte, 8'h5a);
      chk("dma_req_drop", 8'(dma_request), 8'h00);
      dma_en = 1'b0;
      wait_for(1, 1'b0);
      dav_t = 1'b1;
   endtask

   task automatic t_talk();
      wr(hs_pkg::REG_ADDR, 8'h40);
      wr(hs_pkg::REG_DATA, 8'h3c);
      chk("tx_ready", 8'(tx_ready), 8'h01);
      wait_for(2, 1'b1);
      chk("dio_out", dio_out, 8'h3c);
      chk("dio_oe", 8'(dio_oe), 8'h01);
      dac_l = 1'b1;
      wait_for(2, 1'b0);
      wait_for(3, 1'b1);
      rd(hs_pkg::REG_DATA, d);
      chk("data_in_kept", d, 8'h5a);
      dac_l = 1'b0;
   endtask

   task automatic t_get();
      wr(hs_pkg::REG_ADDR, 8'h00);
      atn_t = 1'b0;
      bus_byte({1'b0, hs_pkg::CMD_GET});
      wait_for(1, 1'b0);
      dav_t = 1'b1;
      chk("get_sync_pulse_output", 8'(sync_pulse_output), 8'h01);
      rd(hs_pkg::REG_INT, d);
      chk("get_flag", d & 8'h20, 8'h20);
      bus_byte(8'h3f);
      wait_for(1, 1'b0);
      dav_t = 1'b1;
      chk("get_leave", 8'(sync_pulse_output), 8'h00);
      atn_t = 1'b1;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         close_out();
      end
   end

   initial begin
      {fails, num_checks, cycles} = '0;
      {rst, cs_n, cpu_rw, atn_t, dav_t, rfd_l} = 6'h3f;
      {dac_l, dma_en} = 2'b00;
      register_select = 3'h0;
      {cpu_wdata, dio_t} = 16'h0000;
      switch_in = 8'ha5;
      repeat (12) @(negedge sys_clk);
      chk("rst_sync_pulse_output", 8'(sync_pulse_output), 8'h00);
      chk("rst_ase", 8'(switch_buffer_enable_n), 8'h01);
      chk("rst_dreq", 8'(dma_request), 8'h00);
      rst = 1'b0;
      @(negedge sys_clk);
      t_trigger();
      t_listen_dma();
      t_talk();
      t_get();
      close_out();
   end
endmodule // instrument_bus_dma_handshake_tb_top
